// >>> hdl/program_flow_trace_unit.sv
// Operation
// - program trace start field at 31:29, zero means always on, 1-7 pick watchpoints.
// - program trace stop field at 28:26, same coding, zero means no stop.
// - data trace start field at 25:23, same coding, zero disables.
// - data trace stop field at 22:20, same coding, zero disables.
// - program trace messages, bar the trace-disable correlation, only while trace mode bit is set.
// - indirect branch message with count and target on calls, returns, exceptions.
// - sync message with current pc when trace starts or sync is lost.
// - sync condition plus taken branch sends branch-with-sync instead.
// - buffer overflow sends resource full; counter overflow carries count there.
// - correlation message on trace disable, debug entry, sleep entry.
// - only executed instructions traced; no correction or cancel packets.
// - no messages in debug mode; sync message when debug mode is left.
// - counter adds two per compact and four per extended instruction.
// - taken indirect branch excluded from count; untaken one counted.
// - instructions counted only when executed, never at fetch.
// - counter cleared whenever a program trace message is generated, except on counter overflow, where it keeps the new instruction's size.
// - unique address is new address xor last sent, leading zeros stripped.
// - full address packet carries whole target, leading zeros may drop.
// - debug mode entry sends correlation with event code zero.
// - branch on first instruction after debug exit uses branch-with-sync form.
// - breakpoint on first instruction after debug exit sends correlation code zero.
// - taken direct branch sends direct message, 8-bit count, type code 3.
// - indirect message carries 2-bit cause, type code 4.
// - sync message carries full address and count, type code 9.
`timescale 1ns/1ps
`default_nettype none
`include "trace_cfg.svh"
module program_flow_trace_unit import trace_pkg::*; (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // axi4-lite write
  input wire logic i_awvalid,
  input wire logic [3:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  output logic o_awready,
  input wire logic i_wvalid,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_wready,
  output logic o_bvalid,
  output logic [1:0] o_bresp,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic i_arvalid,
  input wire logic [3:0] i_araddr,
  input wire logic [2:0] i_arprot,
  output logic o_arready,
  output logic o_rvalid,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_rready,
  // retired instruction from the pipeline
  input wire logic i_ret_valid,
  input wire logic i_ret_ext,
  input wire logic [31:0] i_ret_pc,
  input wire logic i_ret_dir_taken,
  input wire logic i_ret_ind_taken,
  input wire logic [31:0] i_ret_target,
  input wire logic [1:0] i_ret_cause,
  input wire logic i_ret_bp_hit,
  // core events
  input wire logic [6:0] i_wp_hit,
  input wire logic i_debug_mode,
  input wire logic i_sleep_mode,
  input wire logic i_buf_overflow,
  input wire logic i_sync_lost,
  // trace message out
  output logic o_msg_valid,
  output logic [5:0] o_msg_tcode,
  output logic [7:0] o_msg_icnt,
  output logic [31:0] o_msg_addr,
  output logic [5:0] o_msg_alen,
  output logic [3:0] o_msg_evt,
  output logic o_prog_trace_on,
  output logic o_data_trace_on
);

  state_s st;
  state_s next_st;

  ////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic sel_hit(input logic [2:0] sel, input logic [6:0] hits);
    logic [2:0] idx;
    idx = sel - 3'h1;
    sel_hit = (sel != 3'h0) && hits[idx];
  endfunction

  function automatic msg_s mk_msg(input logic [5:0] tc, input logic [7:0] cnt,
                                  input logic [31:0] a, input logic [3:0] ev);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 32; i++) begin
      if (a[i]) begin
        n = 6'(i + 1);
      end
    end
    mk_msg.valid = 1'b1;
    mk_msg.tcode = tc;
    mk_msg.icnt = cnt;
    mk_msg.addr = a;
    mk_msg.alen = n;
    mk_msg.evt = ev;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      old[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
    merge = old;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // trace engine

  logic act;
  logic sync_now;
  logic [8:0] sum;
  logic plain_dir;
  logic first_now;
  assign act = st.ctrl[`TM_BIT] &&
               (st.trig[`PTS_HI:`PTS_LO] == 3'h0 || st.prog_on);
  assign sync_now = st.need_sync || i_sync_lost;
  assign sum = {1'b0, st.icnt} + (i_ret_ext ? `SZ_EXTENDED : `SZ_COMPACT);
  // a retire in the exit cycle is already the first one after debug
  assign first_now = st.first_dbg || (st.in_debug && !i_debug_mode);
  assign plain_dir = act && !i_debug_mode && !(i_sleep_mode && !st.in_sleep) &&
                     !i_buf_overflow && i_ret_valid && !(first_now && i_ret_bp_hit) &&
                     !i_ret_ind_taken && i_ret_dir_taken && !sync_now && !sum[8];

  always_comb begin
    next_st = st;
    next_st.msg = '0;
    if (sel_hit(st.trig[`PTS_HI:`PTS_LO], i_wp_hit)) begin
      next_st.prog_on = 1'b1;
    end
    if (sel_hit(st.trig[`PTE_HI:`PTE_LO], i_wp_hit)) begin
      next_st.prog_on = 1'b0;
    end
    if (sel_hit(st.trig[`DTS_HI:`DTS_LO], i_wp_hit)) begin
      next_st.data_on = 1'b1;
    end
    if (sel_hit(st.trig[`DTE_HI:`DTE_LO], i_wp_hit)) begin
      next_st.data_on = 1'b0;
    end
    next_st.active = act;
    next_st.in_debug = i_debug_mode;
    next_st.in_sleep = i_sleep_mode;
    if (st.in_debug && !i_debug_mode) begin
      next_st.first_dbg = 1'b1;
    end
    if (!act) begin
      if (st.active && !(st.in_debug && i_debug_mode)) begin
        next_st.msg = mk_msg(`TC_CORR, st.icnt, 32'h0, `EVC_OFF);
      end
      next_st.icnt = 8'h00;
      next_st.need_sync = 1'b1;
    end else if (i_debug_mode) begin
      if (!st.in_debug) begin
        next_st.msg = mk_msg(`TC_CORR, st.icnt, 32'h0, `EVC_DEBUG);
      end
      next_st.icnt = 8'h00;
      next_st.need_sync = 1'b1;
    end else if (i_sleep_mode && !st.in_sleep) begin
      next_st.msg = mk_msg(`TC_CORR, st.icnt, 32'h0, `EVC_SLEEP);
      next_st.icnt = 8'h00;
      next_st.need_sync = 1'b1;
    end else if (i_buf_overflow) begin
      next_st.msg = mk_msg(`TC_RFULL, st.icnt, 32'h0, 4'h0);
      next_st.icnt = 8'h00;
      next_st.need_sync = 1'b1;
    end else if (i_ret_valid) begin
      next_st.first_dbg = 1'b0;
      if (first_now && i_ret_bp_hit) begin
        next_st.msg = mk_msg(`TC_CORR, st.icnt, 32'h0, `EVC_DEBUG);
        next_st.icnt = 8'h00;
      end else if (i_ret_ind_taken) begin
        if (sync_now) begin
          next_st.msg = mk_msg(`TC_ISYNC, st.icnt, i_ret_target, {2'h0, i_ret_cause});
        end else begin
          next_st.msg = mk_msg(`TC_IND, st.icnt, i_ret_target ^ st.last_addr,
                               {2'h0, i_ret_cause});
        end
        next_st.last_addr = i_ret_target;
        next_st.icnt = 8'h00;
        next_st.need_sync = 1'b0;
      end else if (sum[8]) begin
        next_st.msg = mk_msg(`TC_RFULL, st.icnt, 32'h0, 4'h0);
        next_st.icnt = sum[7:0] - st.icnt;
        next_st.need_sync = 1'b1;
      end else if (i_ret_dir_taken) begin
        if (sync_now) begin
          next_st.msg = mk_msg(`TC_DSYNC, sum[7:0], i_ret_target, 4'h0);
          next_st.last_addr = i_ret_target;
        end else begin
          next_st.msg = mk_msg(`TC_DIR, sum[7:0], 32'h0, 4'h0);
        end
        next_st.icnt = 8'h00;
        next_st.need_sync = 1'b0;
      end else if (sync_now) begin
        next_st.msg = mk_msg(`TC_SYNC, sum[7:0], i_ret_pc, 4'h0);
        next_st.last_addr = i_ret_pc;
        next_st.icnt = 8'h00;
        next_st.need_sync = 1'b0;
      end else begin
        next_st.icnt = sum[7:0];
      end
    end else if (i_sync_lost) begin
      next_st.need_sync = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // axi4-lite slave
    if (i_awvalid && st.awready) begin
      next_st.aw_full = 1'b1;
      next_st.awaddr = i_awaddr;
    end
    if (i_wvalid && st.wready) begin
      next_st.w_full = 1'b1;
      next_st.wdata = i_wdata;
      next_st.wstrb = i_wstrb;
    end
    if (st.bvalid && i_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_full && st.w_full && !st.bvalid) begin
      next_st.aw_full = 1'b0;
      next_st.w_full = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `RESP_OKAY;
      if (st.awaddr == `TRIG_OFS) begin
        next_st.trig = merge(st.trig, st.wdata, st.wstrb) & `TRIG_MASK;
      end else if (st.awaddr == `CTRL_OFS) begin
        next_st.ctrl = merge(st.ctrl, st.wdata, st.wstrb) & `CTRL_MASK;
      end else if (st.awaddr == `STAT_OFS) begin
        next_st.bresp = `RESP_OKAY;
      end else begin
        next_st.bresp = `RESP_SLVERR;
      end
    end
    next_st.awready = !next_st.aw_full && !next_st.bvalid;
    next_st.wready = !next_st.w_full && !next_st.bvalid;
    if (st.rvalid && i_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (i_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `RESP_OKAY;
      next_st.rdata = 32'h0;
      if (i_araddr == `TRIG_OFS) begin
        next_st.rdata = st.trig;
      end else if (i_araddr == `CTRL_OFS) begin
        next_st.rdata = st.ctrl;
      end else if (i_araddr == `STAT_OFS) begin
        next_st.rdata[7:0] = st.icnt;
        next_st.rdata[`ST_ACT] = st.active;
        next_st.rdata[`ST_SYNC] = st.need_sync;
        next_st.rdata[`ST_DBG] = st.in_debug;
        next_st.rdata[`ST_DATA] = st.data_on;
      end else begin
        next_st.rresp = `RESP_SLVERR;
      end
    end
    next_st.arready = !next_st.rvalid;
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
      st.trig <= `TRIG_RST;
      st.ctrl <= `CTRL_RST;
      st.need_sync <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_awready = st.awready;
  assign o_wready = st.wready;
  assign o_bvalid = st.bvalid;
  assign o_bresp = st.bresp;
  assign o_arready = st.arready;
  assign o_rvalid = st.rvalid;
  assign o_rdata = st.rdata;
  assign o_rresp = st.rresp;
  assign o_msg_valid = st.msg.valid;
  assign o_msg_tcode = st.msg.tcode;
  assign o_msg_icnt = st.msg.icnt;
  assign o_msg_addr = st.msg.addr;
  assign o_msg_alen = st.msg.alen;
  assign o_msg_evt = st.msg.evt;
  assign o_prog_trace_on = st.active;
  assign o_data_trace_on = st.data_on;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  sequence dbg_exit_s;
    st.in_debug && !i_debug_mode && act;
  endsequence
  sequence quiet_retire_s;
    i_ret_valid && !i_ret_dir_taken && !i_ret_ind_taken && !i_ret_bp_hit &&
      !i_buf_overflow && !i_sleep_mode && !i_sync_lost;
  endsequence

  no_debug_msg_a: assert property (
    st.in_debug && i_debug_mode && st.active |=> !o_msg_valid)
    else $error("message while in debug mode");
  debug_entry_corr_a: assert property (
    act && i_debug_mode && !st.in_debug |=>
      o_msg_valid && o_msg_tcode == `TC_CORR && o_msg_evt == `EVC_DEBUG)
    else $error("debug entry without correlation");
  mode_gate_a: assert property (
    !st.ctrl[`TM_BIT] && !st.active |=> !o_msg_valid)
    else $error("message with trace mode off");
  direct_msg_a: assert property (
    plain_dir |=> o_msg_valid && o_msg_tcode == `TC_DIR && o_msg_icnt == $past(sum[7:0]))
    else $error("direct branch message wrong");
  count_clear_a: assert property (
    o_msg_valid && o_msg_tcode != `TC_RFULL |-> st.icnt == 8'h00)
    else $error("counter not cleared");
  count_step_a: assert property (
    (act && st.first_dbg == 1'b0 && !i_debug_mode && !st.need_sync && !sum[8]) and
      quiet_retire_s |=> st.icnt == $past(st.icnt) +
      ($past(i_ret_ext) ? 8'(`SZ_EXTENDED) : 8'(`SZ_COMPACT)))
    else $error("counter step wrong");
  ind_count_a: assert property (
    act && !i_debug_mode && !i_sleep_mode && !i_buf_overflow && !st.first_dbg
      && i_ret_valid && i_ret_ind_taken && !sync_now |=>
      o_msg_tcode == `TC_IND && o_msg_icnt == $past(st.icnt)
      && o_msg_addr == $past(i_ret_target ^ st.last_addr))
    else $error("indirect message wrong");
  exit_sync_a: assert property (
    (dbg_exit_s and !i_ret_valid) ##1 (quiet_retire_s and (act && !i_debug_mode))
      |=> o_msg_valid && o_msg_tcode == `TC_SYNC)
    else $error("no sync message after debug exit");
  exit_need_a: assert property (
    dbg_exit_s |-> st.need_sync)
    else $error("no sync pending after debug exit");
  trig_rsvd_a: assert property (
    o_rvalid |-> (st.trig & ~`TRIG_MASK) == 32'h0)
    else $error("reserved trigger bits set");
  prog_start_a: assert property (
    st.trig[`PTS_HI:`PTS_LO] == 3'h1 && st.trig[`PTE_HI:`PTE_LO] == 3'h2 &&
      i_wp_hit[0] && !i_wp_hit[1] |=> st.prog_on)
    else $error("program trace did not start");
  prog_stop_a: assert property (
    st.trig[`PTE_HI:`PTE_LO] == 3'h2 && i_wp_hit[1] |=> !st.prog_on)
    else $error("program trace did not stop");
  data_start_a: assert property (
    st.trig[`DTS_HI:`DTS_LO] == 3'h6 && st.trig[`DTE_HI:`DTE_LO] == 3'h7 &&
      i_wp_hit[5] && !i_wp_hit[6] |=> o_data_trace_on)
    else $error("data trace did not start");
  data_stop_a: assert property (
    st.trig[`DTE_HI:`DTE_LO] == 3'h7 && i_wp_hit[6] |=> !o_data_trace_on)
    else $error("data trace did not stop");
  addr_len_a: assert property (
    o_msg_valid |-> (o_msg_addr >> o_msg_alen) == 32'h0 &&
      (o_msg_alen == 6'h00 || o_msg_addr[5'(o_msg_alen - 6'h01)]))
    else $error("address length wrong");
  count_wrap_a: assert property (
    act && !i_debug_mode && !i_sleep_mode && !i_buf_overflow && !first_now && i_ret_valid
      && !i_ret_ind_taken && sum[8] |=>
      o_msg_valid && o_msg_tcode == `TC_RFULL && o_msg_icnt == $past(st.icnt))
    else $error("counter overflow not reported");

endmodule
`default_nettype wire

// >>> hdl/trace_cfg.svh
`ifndef TRACE_CFG_SVH
`define TRACE_CFG_SVH
// register byte offsets
`define TRIG_OFS 4'h0
`define CTRL_OFS 4'h4
`define STAT_OFS 4'h8
// trigger fields
`define PTS_HI 31
`define PTS_LO 29
`define PTE_HI 28
`define PTE_LO 26
`define DTS_HI 25
`define DTS_LO 23
`define DTE_HI 22
`define DTE_LO 20
`define TRIG_MASK 32'hfff0_0000
`define TRIG_RST 32'h0000_0000
// control fields
`define TM_BIT 2
`define CTRL_MASK 32'h0000_0004
`define CTRL_RST 32'h0000_0000
// status fields
`define ST_ACT 8
`define ST_SYNC 9
`define ST_DBG 10
`define ST_DATA 11
// message type codes
`define TC_DIR 6'h03
`define TC_IND 6'h04
`define TC_SYNC 6'h09
`define TC_DSYNC 6'h0b
`define TC_ISYNC 6'h0c
`define TC_RFULL 6'h1b
`define TC_CORR 6'h21
// correlation event codes
`define EVC_DEBUG 4'h0
`define EVC_SLEEP 4'h1
`define EVC_OFF 4'h4
// instruction sizes in bytes
`define SZ_COMPACT 9'h002
`define SZ_EXTENDED 9'h004
// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> hdl/trace_pkg.sv
`include "trace_cfg.svh"
package trace_pkg;
  typedef struct packed {
    logic valid;
    logic [5:0] tcode;
    logic [7:0] icnt;
    logic [31:0] addr;
    logic [5:0] alen;
    logic [3:0] evt;
  } msg_s;
  typedef struct packed {
    logic [31:0] trig;
    logic [31:0] ctrl;
    logic prog_on;
    logic data_on;
    logic active;
    logic [7:0] icnt;
    logic [31:0] last_addr;
    logic need_sync;
    logic in_debug;
    logic first_dbg;
    logic in_sleep;
    msg_s msg;
    logic aw_full;
    logic w_full;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;
endpackage

// >>> sim/trace_tool_model.sv
`timescale 1ns/1ps
`default_nettype none
module trace_tool_model (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // message from the device
  input wire logic i_msg_valid,
  input wire logic [5:0] i_msg_tcode,
  input wire logic [7:0] i_msg_icnt,
  input wire logic [31:0] i_msg_addr,
  input wire logic [5:0] i_msg_alen,
  input wire logic [3:0] i_msg_evt,
  // last message taken and count of messages
  output logic [7:0] o_count,
  output logic [5:0] o_tcode,
  output logic [7:0] o_icnt,
  output logic [31:0] o_addr,
  output logic [5:0] o_alen,
  output logic [3:0] o_evt
);
  // listens only; a message stands one cycle, so it is taken at that edge
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_count <= 8'h00;
      o_tcode <= 6'h00;
      o_icnt <= 8'h00;
      o_addr <= 32'h0000_0000;
      o_alen <= 6'h00;
      o_evt <= 4'h0;
    end else if (i_msg_valid) begin
      o_count <= o_count + 8'h01;
      o_tcode <= i_msg_tcode;
      o_icnt <= i_msg_icnt;
      o_addr <= i_msg_addr;
      o_alen <= i_msg_alen;
      o_evt <= i_msg_evt;
    end
  end
endmodule
`default_nettype wire

// >>> sim/program_flow_trace_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "trace_cfg.svh"
module program_flow_trace_unit_tb;
  logic i_ref_clk = 0, i_reset_n = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
  logic i_arvalid = 0, i_rready = 0, i_ret_valid = 0, i_ret_ext = 0, i_ret_bp_hit = 0;
  logic i_ret_dir_taken = 0, i_ret_ind_taken = 0, i_debug_mode = 0, i_sleep_mode = 0;
  logic i_buf_overflow = 0, i_sync_lost = 0;
  logic [3:0] i_awaddr = 0, i_araddr = 0, i_wstrb = 0;
  logic [2:0] i_awprot = 0, i_arprot = 0;
  logic [31:0] i_wdata = 0, i_ret_pc = 0, i_ret_target = 0;
  logic [1:0] i_ret_cause = 0;
  logic [6:0] i_wp_hit = 0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_msg_valid;
  logic o_prog_trace_on, o_data_trace_on;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata, o_msg_addr, m_ad, last, t;
  logic [5:0] o_msg_tcode, o_msg_alen, m_tc, m_al;
  logic [7:0] o_msg_icnt, cnt, m_ic;
  logic [3:0] o_msg_evt, m_ev;
  int miscompares = 0, n_checks = 0, n_msg = 0;
  program_flow_trace_unit dut (.i_ref_clk, .i_reset_n, .i_awvalid, .i_awaddr, .i_awprot,
    .o_awready, .i_wvalid, .i_wdata, .i_wstrb, .o_wready, .o_bvalid, .o_bresp, .i_bready,
    .i_arvalid, .i_araddr, .i_arprot, .o_arready, .o_rvalid, .o_rdata, .o_rresp, .i_rready,
    .i_ret_valid, .i_ret_ext, .i_ret_pc, .i_ret_dir_taken, .i_ret_ind_taken, .i_ret_target,
    .i_ret_cause, .i_ret_bp_hit, .i_wp_hit, .i_debug_mode, .i_sleep_mode, .i_buf_overflow,
    .i_sync_lost, .o_msg_valid, .o_msg_tcode, .o_msg_icnt, .o_msg_addr, .o_msg_alen,
    .o_msg_evt, .o_prog_trace_on, .o_data_trace_on);
  trace_tool_model tool (.i_ref_clk, .i_reset_n, .i_msg_valid(o_msg_valid),
    .i_msg_tcode(o_msg_tcode), .i_msg_icnt(o_msg_icnt), .i_msg_addr(o_msg_addr),
    .i_msg_alen(o_msg_alen), .i_msg_evt(o_msg_evt), .o_count(cnt), .o_tcode(m_tc),
    .o_icnt(m_ic), .o_addr(m_ad), .o_alen(m_al), .o_evt(m_ev));
  always #2.5 i_ref_clk = ~i_ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge i_ref_clk);
    i_awvalid <= 1; i_awaddr <= a; i_wvalid <= 1; i_wdata <= d; i_wstrb <= 4'hf;
    i_bready <= 1;
    repeat (50) begin
      @(posedge i_ref_clk);
      if (o_awready) i_awvalid <= 0;
      if (o_wready) i_wvalid <= 0;
      if (o_bvalid) break;
    end
    chk(40'({o_bvalid, o_bresp}), 40'({1'b1, r}));
    i_bready <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge i_ref_clk);
    i_arvalid <= 1; i_araddr <= a; i_rready <= 1;
    repeat (50) begin
      @(posedge i_ref_clk);
      if (o_arready) i_arvalid <= 0;
      if (o_rvalid) break;
    end
    chk(40'({o_rvalid, o_rresp, o_rdata}), 40'({1'b1, r, d}));
    i_rready <= 0;
  endtask
  // one retired instruction, then time for the tool to take its message
  task automatic ret(input logic e, d, n, b, input logic [1:0] c, input logic [31:0] p, g);
    @(posedge i_ref_clk);
    i_ret_valid <= 1; i_ret_ext <= e; i_ret_dir_taken <= d; i_ret_ind_taken <= n;
    i_ret_bp_hit <= b; i_ret_cause <= c; i_ret_pc <= p; i_ret_target <= g;
    @(posedge i_ref_clk);
    i_ret_valid <= 0; i_ret_dir_taken <= 0; i_ret_ind_taken <= 0; i_ret_bp_hit <= 0;
    w(2);
  endtask
  task automatic mchk(input logic [5:0] tc);
    n_msg++;
    chk(40'(cnt), 40'(n_msg));
    chk(40'(m_tc), 40'(tc));
  endtask
  // one watchpoint pulse, then time for the trace state to settle
  task automatic hit(input logic [6:0] h);
    @(posedge i_ref_clk);
    i_wp_hit <= h;
    @(posedge i_ref_clk);
    i_wp_hit <= 7'h00;
    w(3);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #25000;
    miscompares++;
    close_out();
  end
  initial begin
    w(20);
    i_reset_n <= 1;
    w(2);
    rd(`TRIG_OFS, 32'h0, `RESP_OKAY);
    rd(`CTRL_OFS, 32'h0, `RESP_OKAY);
    wr(`TRIG_OFS, 32'hffff_ffff, `RESP_OKAY);
    rd(`TRIG_OFS, 32'hfff0_0000, `RESP_OKAY);
    wr(`TRIG_OFS, 32'h0, `RESP_OKAY);
    rd(4'hc, 32'h0, `RESP_SLVERR);
    wr(4'hc, 32'h1, `RESP_SLVERR);
    wr(`CTRL_OFS, 32'h4, `RESP_OKAY);
    w(2);
    chk(40'(o_prog_trace_on), 40'h1);
    ret(0, 0, 0, 0, 2'h0, 32'h100, 32'h0);
    mchk(`TC_SYNC);
    chk(40'({m_ic, m_ad}), 40'({8'h02, 32'h100}));
    ret(0, 0, 0, 0, 2'h0, 32'h102, 32'h0);
    ret(1, 0, 0, 0, 2'h0, 32'h104, 32'h0);
    chk(40'(cnt), 40'(n_msg));
    ret(0, 1, 0, 0, 2'h0, 32'h108, 32'h180);
    mchk(`TC_DIR);
    chk(40'(m_ic), 40'h8);
    ret(0, 0, 0, 0, 2'h0, 32'h180, 32'h0);
    ret(1, 0, 1, 0, 2'h2, 32'h182, 32'h3000);
    mchk(`TC_IND);
    chk(40'({m_ic, m_ev}), 40'({8'h02, 4'h2}));
    chk(40'({m_ad, m_al}), 40'({32'h3100, 6'h0e}));
    last = 32'h3000;
    for (int k = 0; k < 4; k++) begin
      t = 32'h40 << (4 * k);
      ret(0, 0, 1, 0, 2'(k), 32'h190, t);
      mchk(`TC_IND);
      chk(40'({m_ic, m_ev}), 40'({8'h00, 4'(k)}));
      chk(40'(m_ad), 40'(t ^ last));
      last = t;
    end
    @(posedge i_ref_clk); i_buf_overflow <= 1;
    @(posedge i_ref_clk); i_buf_overflow <= 0;
    w(2);
    mchk(`TC_RFULL);
    ret(0, 0, 1, 0, 2'h1, 32'h1a0, 32'h500);
    mchk(`TC_ISYNC);
    chk(40'(m_ad), 40'h500);
    @(posedge i_ref_clk); i_sync_lost <= 1;
    @(posedge i_ref_clk); i_sync_lost <= 0;
    ret(0, 1, 0, 0, 2'h0, 32'h500, 32'h520);
    mchk(`TC_DSYNC);
    for (int k = 0; k < 64; k++) begin
      ret(1, 0, 0, 0, 2'h0, 32'h520, 32'h0);
    end
    mchk(`TC_RFULL);
    chk(40'(m_ic), 40'hfc);
    @(posedge i_ref_clk); i_sleep_mode <= 1;
    w(3);
    mchk(`TC_CORR);
    chk(40'(m_ev), 40'(`EVC_SLEEP));
    @(posedge i_ref_clk); i_sleep_mode <= 0;
    for (int k = 0; k < 2; k++) begin
      @(posedge i_ref_clk); i_debug_mode <= 1;
      w(3);
      mchk(`TC_CORR);
      chk(40'(m_ev), 40'(`EVC_DEBUG));
      ret(0, 1, 0, 0, 2'h0, 32'h600, 32'h640);
      chk(40'(cnt), 40'(n_msg));
      @(posedge i_ref_clk); i_debug_mode <= 0;
      ret(0, 1 - k, 0, k, 2'h0, 32'h700, 32'h740);
      mchk(k == 0 ? `TC_DSYNC : `TC_CORR);
      if (k == 1) chk(40'(m_ev), 40'(`EVC_DEBUG));
    end
    @(posedge i_ref_clk); i_debug_mode <= 1;
    w(3);
    mchk(`TC_CORR);
    @(posedge i_ref_clk); i_debug_mode <= 0;
    ret(1, 0, 0, 0, 2'h0, 32'h780, 32'h0);
    mchk(`TC_SYNC);
    chk(40'({m_ic, m_ad}), 40'({8'h04, 32'h780}));
    wr(`CTRL_OFS, 32'h0, `RESP_OKAY);
    w(4);
    mchk(`TC_CORR);
    chk(40'({m_ev, o_prog_trace_on}), 40'({`EVC_OFF, 1'b0}));
    ret(0, 1, 0, 0, 2'h0, 32'h800, 32'h840);
    chk(40'(cnt), 40'(n_msg));
    wr(`TRIG_OFS, 32'h2b70_0000, `RESP_OKAY);
    wr(`CTRL_OFS, 32'h4, `RESP_OKAY);
    hit(7'h04);
    chk(40'({o_prog_trace_on, o_data_trace_on}), 40'h0);
    hit(7'h01);
    chk(40'({o_prog_trace_on, o_data_trace_on}), 40'h2);
    ret(0, 0, 0, 0, 2'h0, 32'h900, 32'h0);
    mchk(`TC_SYNC);
    chk(40'(m_ad), 40'h900);
    hit(7'h20);
    chk(40'(o_data_trace_on), 40'h1);
    hit(7'h40);
    chk(40'(o_data_trace_on), 40'h0);
    hit(7'h02);
    chk(40'(o_prog_trace_on), 40'h0);
    mchk(`TC_CORR);
    close_out();
  end
endmodule
`default_nettype wire
